//--- common/pwmc_map.vh
`ifndef PWMC_MAP_VH
`define PWMC_MAP_VH

// Register indices; the byte address of a register is four times its index.
`define PWMC_IDX_ENABLE_CTRL   8'h30
`define PWMC_IDX_FREQ_CTRL     8'h31
`define PWMC_IDX_COUNTER_VIEW  8'h32
`define PWMC_IDX_MODE_CTRL     8'h38
`define PWMC_IDX_W             8
`define PWMC_ADDR_LSB          2
`define PWMC_ADDR_MSB          9

// Enable-control fields.
`define PWMC_ENC_GEN_ENABLE    7
`define PWMC_ENC_LOAD_OKAY     1
`define PWMC_ENC_RELOAD_IE     0

// Frequency-control fields.
`define PWMC_FQC_FREQ_MSB      7
`define PWMC_FQC_FREQ_LSB      4
`define PWMC_FQC_HALF          3
`define PWMC_FQC_DIV_MSB       2
`define PWMC_FQC_DIV_LSB       1
`define PWMC_FQC_FLAG          0

// Mode-control fields.
`define PWMC_MOD_MULTI_GEN     0
`define PWMC_MOD_EDGE          1
`define PWMC_MOD_OVR4          2
`define PWMC_MOD_OVR5          3

// Widths and reset values.
`define PWMC_FREQ_W            4
`define PWMC_DIV_W             2
`define PWMC_CNT_W             15
`define PWMC_VAL_W             16
`define PWMC_DIVCNT_W          3
`define PWMC_RST_FREQ          4'h0
`define PWMC_RST_DIV           2'h0
`define PWMC_RST_DIVCNT        3'h0
`define PWMC_RST_MODULUS       15'h0000
`define PWMC_RST_VALUE         16'h0000
`define PWMC_RST_DATA          32'h0000_0000
`define PWMC_DIV_SEL_1         2'h0
`define PWMC_DIV_SEL_2         2'h1
`define PWMC_DIV_SEL_4         2'h2
`define PWMC_MASK_1            3'h0
`define PWMC_MASK_2            3'h1
`define PWMC_MASK_4            3'h3
`define PWMC_MASK_8            3'h7

`endif

//--- hdl/pwmc_prescaler.v
`timescale 1ns/1ps
`include "pwmc_map.vh"

module pwmc_prescaler (
	input  wire                      sys_clk_i,
	input  wire                      nrst_i,
	input  wire [`PWMC_DIV_W-1:0]    div_sel_i,
	output wire                      pwm_clk_en_o
);

	reg  [`PWMC_DIVCNT_W-1:0] cnt_q;
	reg                       en_q;

	function [`PWMC_DIVCNT_W-1:0] div_mask;
		input [`PWMC_DIV_W-1:0] sel;
		begin
			case (sel)
				`PWMC_DIV_SEL_1: div_mask = `PWMC_MASK_1;
				`PWMC_DIV_SEL_2: div_mask = `PWMC_MASK_2;
				`PWMC_DIV_SEL_4: div_mask = `PWMC_MASK_4;
				default:         div_mask = `PWMC_MASK_8;
			endcase
		end
	endfunction

	// A free-running count avoids a restart glitch when the divider changes at a reload.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			cnt_q <= `PWMC_RST_DIVCNT;
			en_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
			en_q  <= ((cnt_q & div_mask(div_sel_i)) == div_mask(div_sel_i));
		end
	end

	assign pwm_clk_en_o = en_q;

endmodule // pwmc_prescaler

//--- hdl/pwmc_reload_seq.v
`timescale 1ns/1ps
`include "pwmc_map.vh"

module pwmc_reload_seq (
	input  wire                      sys_clk_i,
	input  wire                      nrst_i,
	input  wire                      run_i,
	input  wire                      opportunity_i,
	input  wire [`PWMC_FREQ_W-1:0]   freq_buf_i,
	output wire                      reload_o
);

	reg  [`PWMC_FREQ_W-1:0] count_q;
	reg  [`PWMC_FREQ_W-1:0] freq_work_q;
	reg                     reload_q;

	always @(posedge sys_clk_i) begin
		if (!nrst_i || !run_i) begin
			count_q     <= `PWMC_RST_FREQ;
			freq_work_q <= `PWMC_RST_FREQ;
			reload_q    <= 1'b0;
		end else begin
			reload_q <= 1'b0;
			if (opportunity_i) begin
				if (count_q == freq_work_q) begin
					count_q     <= `PWMC_RST_FREQ;
					freq_work_q <= freq_buf_i;
					reload_q    <= 1'b1;
				end else begin
					count_q <= count_q + 4'h1;
				end
			end
		end
	end

	assign reload_o = reload_q;

endmodule // pwmc_reload_seq

//--- hdl/pwmc_reload_control.v
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "pwmc_map.vh"


module pwmc_reload_control (
	input  wire                      sys_clk_i,
	input  wire                      nrst_i,
	// Classic Wishbone slave.
	input  wire                      wb_cyc_i,
	input  wire                      wb_stb_i,
	input  wire                      wb_we_i,
	input  wire [31:0]               wb_adr_i,
	input  wire [3:0]                wb_sel_i,
	input  wire [31:0]               wb_dat_i,
	output wire [31:0]               wb_dat_o,
	output wire                      wb_ack_o,
	// Generator C datapath.
	input  wire                      cycle_start_i,
	input  wire                      half_cycle_i,
	input  wire [`PWMC_CNT_W-1:0]    counter_c_value_i,
	input  wire [`PWMC_CNT_W-1:0]    period_modulus_c_i,
	input  wire [`PWMC_VAL_W-1:0]    pulse_value_4_i,
	input  wire [`PWMC_VAL_W-1:0]    pulse_value_5_i,
	output wire                      gen_c_run_o,
	output wire                      pwm_clk_en_o,
	output wire                      reload_strobe_o,
	output wire [`PWMC_CNT_W-1:0]    period_modulus_work_o,
	output wire [`PWMC_VAL_W-1:0]    pulse_value_4_work_o,
	output wire [`PWMC_VAL_W-1:0]    pulse_value_5_work_o,
	output wire                      pin4_enable_o,
	output wire                      pin5_enable_o,
	output wire                      multi_generator_select_o,
	output wire                      edge_aligned_c_o,
	output wire                      reload_irq_c_o
);

	// Control bits.
	reg                       multi_generator_select_q;
	reg                       edge_aligned_q;
	reg                       sw_output_override_4_q;
	reg                       sw_output_override_5_q;
	reg                       gen_c_enable_q;
	reg                       load_okay_c_q;
	reg                       reload_irq_enable_c_q;
	reg  [`PWMC_FREQ_W-1:0]   reload_frequency_c_q;
	reg                       half_cycle_reload_c_q;
	reg  [`PWMC_DIV_W-1:0]    clock_divider_select_c_q;
	reg                       reload_flag_c_q;
	reg                       flag_clear_armed_q;

	// Working buffers.
	reg  [`PWMC_DIV_W-1:0]    div_work_q;
	reg  [`PWMC_CNT_W-1:0]    modulus_work_q;
	reg  [`PWMC_VAL_W-1:0]    value4_work_q;
	reg  [`PWMC_VAL_W-1:0]    value5_work_q;

	// Bus side.
	reg                       ack_q;
	reg  [31:0]               dat_q;
	reg  [31:0]               rd_data;

	wire                      reload;
	wire                      opportunity;
	wire                      gen_run;
	wire                      bus_req;
	wire                      wr_lane0;
	wire                      rd_access;
	wire [`PWMC_IDX_W-1:0]    reg_idx;
	wire                      wr_enc;
	wire                      wr_fqc;
	wire                      wr_mode;
	wire                      rd_enc;
	wire                      rd_fqc;
	wire                      flag_clear_req;

	function idx_hit;
		input [`PWMC_IDX_W-1:0] idx;
		input [`PWMC_IDX_W-1:0] target;
		begin
			idx_hit = (idx == target);
		end
	endfunction

	// One access per request; the cycle in which ack is high is always idle, which keeps ack a single pulse.
	assign bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr_lane0  = bus_req & wb_we_i & wb_sel_i[0];
	assign rd_access = bus_req & ~wb_we_i;
	assign reg_idx   = wb_adr_i[`PWMC_ADDR_MSB:`PWMC_ADDR_LSB];

	assign wr_enc  = wr_lane0 & idx_hit(reg_idx, `PWMC_IDX_ENABLE_CTRL) & multi_generator_select_q;
	assign wr_fqc  = wr_lane0 & idx_hit(reg_idx, `PWMC_IDX_FREQ_CTRL) & multi_generator_select_q;
	assign wr_mode = wr_lane0 & idx_hit(reg_idx, `PWMC_IDX_MODE_CTRL);
	assign rd_enc  = rd_access & idx_hit(reg_idx, `PWMC_IDX_ENABLE_CTRL);
	assign rd_fqc  = rd_access & idx_hit(reg_idx, `PWMC_IDX_FREQ_CTRL);

	// Generator C only exists as its own generator when multi-generator select is set.
	assign gen_run = gen_c_enable_q & multi_generator_select_q;

	// Half-cycle opportunities only count in center-aligned operation.
	assign opportunity = gen_run & (cycle_start_i |
		(half_cycle_i & half_cycle_reload_c_q & ~edge_aligned_q));

	assign flag_clear_req = wr_fqc & wb_dat_i[`PWMC_FQC_FLAG] & flag_clear_armed_q;

	pwmc_reload_seq u_reload_seq (
		.sys_clk_i     (sys_clk_i),
		.nrst_i        (nrst_i),
		.run_i         (gen_run),
		.opportunity_i (opportunity),
		.freq_buf_i    (reload_frequency_c_q),
		.reload_o      (reload)
	);

	pwmc_prescaler u_prescaler (
		.sys_clk_i    (sys_clk_i),
		.nrst_i       (nrst_i),
		.div_sel_i    (div_work_q),
		.pwm_clk_en_o (pwm_clk_en_o)
	);

	// Mode-control register; always writable.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			multi_generator_select_q <= 1'b0;
			edge_aligned_q           <= 1'b0;
			sw_output_override_4_q   <= 1'b0;
			sw_output_override_5_q   <= 1'b0;
		end else if (wr_mode) begin
			multi_generator_select_q <= wb_dat_i[`PWMC_MOD_MULTI_GEN];
			edge_aligned_q           <= wb_dat_i[`PWMC_MOD_EDGE];
			sw_output_override_4_q   <= wb_dat_i[`PWMC_MOD_OVR4];
			sw_output_override_5_q   <= wb_dat_i[`PWMC_MOD_OVR5];
		end
	end

	// Enable-control register.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			gen_c_enable_q        <= 1'b0;
			reload_irq_enable_c_q <= 1'b0;
		end else if (wr_enc) begin
			gen_c_enable_q        <= wb_dat_i[`PWMC_ENC_GEN_ENABLE];
			reload_irq_enable_c_q <= wb_dat_i[`PWMC_ENC_RELOAD_IE];
		end
	end

	// A software set in the reload cycle wins, so a freshly armed load is not lost.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			load_okay_c_q <= 1'b0;
		end else if (wr_enc) begin
			load_okay_c_q <= wb_dat_i[`PWMC_ENC_LOAD_OKAY];
		end else if (reload) begin
			load_okay_c_q <= 1'b0;
		end
	end

	// Frequency-control buffered fields.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			reload_frequency_c_q     <= `PWMC_RST_FREQ;
			half_cycle_reload_c_q    <= 1'b0;
			clock_divider_select_c_q <= `PWMC_RST_DIV;
		end else if (wr_fqc) begin
			reload_frequency_c_q     <= wb_dat_i[`PWMC_FQC_FREQ_MSB:`PWMC_FQC_FREQ_LSB];
			half_cycle_reload_c_q    <= wb_dat_i[`PWMC_FQC_HALF];
			clock_divider_select_c_q <= wb_dat_i[`PWMC_FQC_DIV_MSB:`PWMC_FQC_DIV_LSB];
		end
	end

	// Reload flag: a reload in the clearing cycle wins and also disarms the sequence.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			reload_flag_c_q    <= 1'b0;
			flag_clear_armed_q <= 1'b0;
		end else begin
			if (reload) begin
				reload_flag_c_q <= 1'b1;
			end else if (flag_clear_req) begin
				reload_flag_c_q <= 1'b0;
			end
			if (reload || wr_fqc) begin
				flag_clear_armed_q <= 1'b0;
			end else if (rd_fqc && reload_flag_c_q) begin
				flag_clear_armed_q <= 1'b1;
			end
		end
	end

	// Working buffers change only at a reload that finds load-okay set.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			div_work_q     <= `PWMC_RST_DIV;
			modulus_work_q <= `PWMC_RST_MODULUS;
			value4_work_q  <= `PWMC_RST_VALUE;
			value5_work_q  <= `PWMC_RST_VALUE;
		end else if (reload && load_okay_c_q) begin
			div_work_q     <= clock_divider_select_c_q;
			modulus_work_q <= period_modulus_c_i;
			value4_work_q  <= pulse_value_4_i;
			value5_work_q  <= pulse_value_5_i;
		end
	end

	// Read multiplexer; unused bits and unmapped addresses read zero.
	always @* begin
		rd_data = `PWMC_RST_DATA;
		case (reg_idx)
			`PWMC_IDX_ENABLE_CTRL: begin
				rd_data[`PWMC_ENC_GEN_ENABLE] = gen_c_enable_q & multi_generator_select_q;
				rd_data[`PWMC_ENC_LOAD_OKAY]  = load_okay_c_q & multi_generator_select_q;
				rd_data[`PWMC_ENC_RELOAD_IE]  = reload_irq_enable_c_q & multi_generator_select_q;
			end
			`PWMC_IDX_FREQ_CTRL: begin
				rd_data[`PWMC_FQC_FREQ_MSB:`PWMC_FQC_FREQ_LSB] = reload_frequency_c_q;
				rd_data[`PWMC_FQC_HALF]                        = half_cycle_reload_c_q;
				rd_data[`PWMC_FQC_DIV_MSB:`PWMC_FQC_DIV_LSB]   = clock_divider_select_c_q;
				rd_data[`PWMC_FQC_FLAG]                        = reload_flag_c_q;
			end
			`PWMC_IDX_COUNTER_VIEW: begin
				rd_data[`PWMC_CNT_W-1:0] = counter_c_value_i;
			end
			`PWMC_IDX_MODE_CTRL: begin
				rd_data[`PWMC_MOD_MULTI_GEN] = multi_generator_select_q;
				rd_data[`PWMC_MOD_EDGE]      = edge_aligned_q;
				rd_data[`PWMC_MOD_OVR4]      = sw_output_override_4_q;
				rd_data[`PWMC_MOD_OVR5]      = sw_output_override_5_q;
			end
			default: begin
				rd_data = `PWMC_RST_DATA;
			end
		endcase
	end

	// Every request is answered one cycle after it is taken, mapped or not.
	always @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			ack_q <= 1'b0;
			dat_q <= `PWMC_RST_DATA;
		end else begin
			ack_q <= bus_req;
			if (rd_access) begin
				dat_q <= rd_data;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	assign gen_c_run_o              = gen_run;
	assign reload_strobe_o          = reload;
	assign period_modulus_work_o    = modulus_work_q;
	assign pulse_value_4_work_o     = value4_work_q;
	assign pulse_value_5_work_o     = value5_work_q;
	assign pin4_enable_o            = gen_run | sw_output_override_4_q;
	assign pin5_enable_o            = gen_run | sw_output_override_5_q;
	assign multi_generator_select_o = multi_generator_select_q;
	assign edge_aligned_c_o         = edge_aligned_q;
	assign reload_irq_c_o           = reload_flag_c_q & reload_irq_enable_c_q & multi_generator_select_q;

endmodule // pwmc_reload_control

//--- verification/pwmc_reload_control_chk.sv
`timescale 1ns/1ps
module pwmc_reload_control_chk (
	input wire        sys_clk_i,
	input wire        nrst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire        wb_ack_o,
	input wire        cycle_start_i,
	input wire        half_cycle_i,
	input wire [14:0] period_modulus_c_i,
	input wire        gen_c_run_o,
	input wire        reload_strobe_o,
	input wire [14:0] period_modulus_work_o,
	input wire [15:0] pulse_value_4_work_o,
	input wire [15:0] pulse_value_5_work_o,
	input wire        pin4_enable_o,
	input wire        pin5_enable_o,
	input wire        multi_generator_select_o,
	input wire        edge_aligned_c_o,
	input wire        reload_irq_c_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i;
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus request not answered by one ack pulse");
	property p_mgs; !multi_generator_select_o |-> !gen_c_run_o && !reload_irq_c_o; endproperty
	a_mgs: assert property (p_mgs) else $error("generator active without multi select");
	property p_pins; gen_c_run_o |-> pin4_enable_o && pin5_enable_o; endproperty
	a_pins: assert property (p_pins) else $error("running generator with pins off");
	// The strobe is registered on the edge that takes the opportunity, so the cause is one sample back.
	property p_opp; reload_strobe_o |-> $past(gen_c_run_o) && ($past(cycle_start_i) || $past(half_cycle_i)); endproperty
	a_opp: assert property (p_opp) else $error("reload without an opportunity");
	property p_half; reload_strobe_o && !$past(cycle_start_i) |-> !$past(edge_aligned_c_o); endproperty
	a_half: assert property (p_half) else $error("half cycle reload in edge mode");
	property p_load; !$stable({period_modulus_work_o, pulse_value_4_work_o, pulse_value_5_work_o}) |-> $past(reload_strobe_o); endproperty
	a_load: assert property (p_load) else $error("working buffers changed outside a reload");
	property p_val; !$stable(period_modulus_work_o) |-> period_modulus_work_o == $past(period_modulus_c_i); endproperty
	a_val: assert property (p_val) else $error("working modulus differs from buffer");
	property p_irq_up; $rose(reload_irq_c_o) |-> $past(reload_strobe_o) || $past(bus_wr); endproperty
	a_irq_up: assert property (p_irq_up) else $error("interrupt raised without reload or write");
	property p_irq_dn; $fell(reload_irq_c_o) |-> $past(bus_wr); endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("interrupt dropped without a write");
endmodule // pwmc_reload_control_chk

bind pwmc_reload_control pwmc_reload_control_chk u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
	.cycle_start_i(cycle_start_i), .half_cycle_i(half_cycle_i), .period_modulus_c_i(period_modulus_c_i),
	.gen_c_run_o(gen_c_run_o), .reload_strobe_o(reload_strobe_o), .period_modulus_work_o(period_modulus_work_o),
	.pulse_value_4_work_o(pulse_value_4_work_o), .pulse_value_5_work_o(pulse_value_5_work_o),
	.pin4_enable_o(pin4_enable_o), .pin5_enable_o(pin5_enable_o),
	.multi_generator_select_o(multi_generator_select_o), .edge_aligned_c_o(edge_aligned_c_o),
	.reload_irq_c_o(reload_irq_c_o));

//--- verification/pwmc_reload_control_tb_top.sv
`timescale 1ns/1ps
module pwmc_reload_control_tb_top;
	localparam logic [31:0] A_EN   = 32'h0000_00C0;
	localparam logic [31:0] A_FQ   = 32'h0000_00C4;
	localparam logic [31:0] A_CNT  = 32'h0000_00C8;
	localparam logic [31:0] A_MODE = 32'h0000_00E0;
	localparam logic [31:0] A_NONE = 32'h0000_0100;
	logic        sys_clk = 1'h0;
	logic        nrst    = 1'h0;
	logic        cyc     = 1'h0;
	logic        stb     = 1'h0;
	logic        we      = 1'h0;
	logic        cs      = 1'h0;
	logic        hc      = 1'h0;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] adr     = 32'h0000_0000;
	logic [31:0] wdat    = 32'h0000_0000;
	logic [31:0] q;
	logic [14:0] cnt     = 15'h5A5A;
	logic [14:0] pmod    = 15'h1234;
	logic [15:0] pv4     = 16'hBEEF;
	logic [15:0] pv5     = 16'h8001;
	wire  [31:0] rdat;
	wire  [14:0] pmw;
	wire  [15:0] pw4, pw5;
	wire         ack, run, clken, strb, p4, p5, mgs, edg, irq;
	int          mismatches = 0;
	int          num_checks = 0;
	int          strobes = 0;

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (strb === 1'h1) strobes <= strobes + 1;

	pwmc_reload_control uut (.sys_clk_i(sys_clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cycle_start_i(cs), .half_cycle_i(hc), .counter_c_value_i(cnt), .period_modulus_c_i(pmod),
		.pulse_value_4_i(pv4), .pulse_value_5_i(pv5), .gen_c_run_o(run), .pwm_clk_en_o(clken),
		.reload_strobe_o(strb), .period_modulus_work_o(pmw), .pulse_value_4_work_o(pw4),
		.pulse_value_5_work_o(pw5), .pin4_enable_o(p4), .pin5_enable_o(p5),
		.multi_generator_select_o(mgs), .edge_aligned_c_o(edg), .reload_irq_c_o(irq));

	task automatic tally_and_finish;
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic cycle; the request is held until ack is sampled, then released for a cycle.
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		int k;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= {24'h00_0000, d};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack !== 1'h1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			tally_and_finish;
		end else begin
			q = rdat;
		end
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
		bus(1'h0, a, 8'h00);
		check(nm, q, exp);
	endtask

	// Pulses spaced so that each reload strobe settles before the next opportunity.
	task automatic opp(input int num, input logic h);
		strobes = 0;
		repeat (num) begin
			cs <= !h;
			hc <= h;
			@(posedge sys_clk);
			cs <= 1'h0;
			hc <= 1'h0;
			repeat (4) @(posedge sys_clk);
		end
	endtask

	task automatic clk_count(input int exp);
		int c;
		c = 0;
		repeat (16) begin
			@(posedge sys_clk);
			if (clken === 1'h1) c++;
		end
		check("pwm clock enables", c, exp);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'h1;
		rd("enable ctrl", A_EN, 8'h00);
		rd("freq ctrl", A_FQ, 8'h00);
		rd("mode", A_MODE, 8'h00);
		bus(1'h1, A_EN, 8'h83);
		bus(1'h1, A_FQ, 8'hF6);
		rd("enable masked", A_EN, 8'h00);
		bus(1'h1, A_MODE, 8'h01);
		check("multi select out", mgs, 8'h01);
		check("edge out", edg, 8'h00);
		check("pins idle", {p5, p4}, 8'h00);
		rd("enable ignored", A_EN, 8'h00);
		rd("freq ignored", A_FQ, 8'h00);
		rd("counter", A_CNT, 16'h5A5A);
		bus(1'h1, A_CNT, 8'h00);
		rd("counter after write", A_CNT, 16'h5A5A);
		rd("unmapped", A_NONE, 8'h00);
		bus(1'h1, A_EN, 8'h02);
		rd("load okay", A_EN, 8'h02);
		bus(1'h1, A_EN, 8'h00);
		rd("load okay cleared", A_EN, 8'h00);
		bus(1'h1, A_FQ, 8'h12);
		rd("freq buffered", A_FQ, 8'h12);
		bus(1'h1, A_EN, 8'h02);
		bus(1'h1, A_EN, 8'h83);
		check("run", run, 8'h01);
		check("pins", {p5, p4}, 8'h03);
		clk_count(16);
		opp(1, 1'h0);
		check("first reload", strobes, 1);
		check("modulus work", pmw, pmod);
		check("pulse 4 work", pw4, pv4);
		check("pulse 5 work", pw5, pv5);
		rd("load okay self clear", A_EN, 8'h81);
		check("irq", irq, 8'h01);
		clk_count(8);
		opp(4, 1'h0);
		check("reloads every second", strobes, 2);
		rd("flag set", A_FQ, 8'h13);
		bus(1'h1, A_FQ, 8'h13);
		rd("flag cleared", A_FQ, 8'h12);
		check("irq withdrawn", irq, 8'h00);
		opp(2, 1'h0);
		rd("flag again", A_FQ, 8'h13);
		opp(2, 1'h0);
		bus(1'h1, A_FQ, 8'h13);
		rd("flag kept", A_FQ, 8'h13);
		bus(1'h1, A_FQ, 8'h1A);
		opp(4, 1'h1);
		check("half reloads center", strobes, 2);
		bus(1'h1, A_MODE, 8'h03);
		check("edge out set", edg, 8'h01);
		opp(4, 1'h1);
		check("half reloads edge", strobes, 0);
		bus(1'h1, A_EN, 8'h01);
		bus(1'h1, A_MODE, 8'h05);
		check("pins override", {p5, p4}, 8'h01);
		opp(2, 1'h0);
		check("no reload stopped", strobes, 0);
		bus(1'h1, A_MODE, 8'h00);
		rd("irq enable masked", A_EN, 8'h00);
		check("multi select cleared", mgs, 8'h00);
		check("run masked", run, 8'h00);
		check("irq masked", irq, 8'h00);
		tally_and_finish;
	end
endmodule // pwmc_reload_control_tb_top
